// file: kli_pkg.sv
// package: register map, widths and reset values of the keypad level unit
package kli_pkg;
  localparam int KLI_LINES = 8;
  localparam int KLI_AW = 8;
  localparam int KLI_DW = 8;
  localparam logic [7:0] KLI_OFS_LEVEL_SELECT = 8'h9C;
  localparam logic [7:0] KLI_OFS_LINE_ENABLE = 8'h9D;
  localparam logic [7:0] KLI_OFS_LINE_FLAGS = 8'h9E;
  localparam logic [7:0] KLI_RST_BYTE = 8'h00;
  localparam logic [7:0] KLI_READ_ZERO = 8'h00;
  localparam logic [KLI_LINES-1:0] KLI_LINE_IDLE = 8'hFF;
endpackage

// file: kli_keypad.sv
// module: eight-line keypad level-detect interrupt unit
// Operation
// - line at selected level sets its flag
// - flag requests interrupt only when enabled
// - flags read-only, read clears all eight except lines still at their selected level
// - all three registers reset to zero
// - disabled line takes no part in interrupts
// - enabled line flag may request interrupt
// - select zero detects low level
// - select one detects high level
// - one shared request, gated by global enable
// - detected level on an enabled line raises wake-up request
module kli_keypad (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // special function register access
  input wire logic [kli_pkg::KLI_AW-1:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [kli_pkg::KLI_DW-1:0] sfr_wdata,
  output logic [kli_pkg::KLI_DW-1:0] sfr_rdata,
  // core interrupt side
  input wire logic keypad_global_irq_enable,
  output logic keypad_irq,
  output logic keypad_wake,
  // keyboard matrix lines
  input wire logic [kli_pkg::KLI_LINES-1:0] port_one
);
  import kli_pkg::*;

  // ==========================================================
  // register state
  // ==========================================================
  typedef struct packed {
    logic [KLI_LINES-1:0] sync1;
    logic [KLI_LINES-1:0] sync2;
    logic [KLI_DW-1:0] level_select;
    logic [KLI_DW-1:0] line_enable;
    logic [KLI_DW-1:0] line_flags;
    logic [KLI_DW-1:0] rdata;
    logic irq;
    logic wake;
  } kli_state_t;

  // lines idle high on their pull-ups; a zero here would read
  // as a held key and flag every line straight out of reset
  localparam kli_state_t KLI_ST_RESET = '{
    sync1: KLI_LINE_IDLE,
    sync2: KLI_LINE_IDLE,
    default: '0
  };

  kli_state_t st_reg;
  kli_state_t st_next;
  logic [KLI_LINES-1:0] hit;
  logic [KLI_LINES-1:0] flags_set;

  function automatic logic addr_is(input logic [KLI_AW-1:0] a,
                                   input logic [KLI_AW-1:0] ofs);
    addr_is = (a == ofs);
  endfunction

  // ==========================================================
  // level compare per line
  // ==========================================================
  genvar gi;
  generate
    for (gi = 0; gi < KLI_LINES; gi++) begin : g_line
      assign hit[gi] = (st_reg.sync2[gi] == st_reg.level_select[gi]);
    end
  endgenerate

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    st_next = st_reg;
    st_next.sync1 = port_one;
    st_next.sync2 = st_reg.sync1;
    if (sfr_wr && addr_is(sfr_addr, KLI_OFS_LEVEL_SELECT)) begin
      st_next.level_select = sfr_wdata;
    end
    if (sfr_wr && addr_is(sfr_addr, KLI_OFS_LINE_ENABLE)) begin
      st_next.line_enable = sfr_wdata;
    end
    // held key re-flags at once
    // a clearing read never loses a level seen in the same cycle
    if (sfr_rd && addr_is(sfr_addr, KLI_OFS_LINE_FLAGS)) begin
      st_next.line_flags = hit;
    end else begin
      st_next.line_flags = st_reg.line_flags | hit;
    end
    // read data stands one cycle, zero otherwise and when unmapped
    st_next.rdata = KLI_READ_ZERO;
    if (sfr_rd) begin
      if (addr_is(sfr_addr, KLI_OFS_LEVEL_SELECT)) begin
        st_next.rdata = st_reg.level_select;
      end else if (addr_is(sfr_addr, KLI_OFS_LINE_ENABLE)) begin
        st_next.rdata = st_reg.line_enable;
      end else if (addr_is(sfr_addr, KLI_OFS_LINE_FLAGS)) begin
        st_next.rdata = st_reg.line_flags;
      end
    end
    st_next.irq = keypad_global_irq_enable
                  && |(st_reg.line_flags & st_reg.line_enable);
    // wake on any enabled flag, ungated by global enable
    st_next.wake = |(st_reg.line_flags & st_reg.line_enable);
  end

  // ==========================================================
  // register update
  // ==========================================================
  // reset clears the registers, synchronisers load idle high
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= KLI_ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs, all straight from the state flops
  // ==========================================================
  assign flags_set = st_reg.line_flags;
  assign sfr_rdata = st_reg.rdata;
  assign keypad_irq = st_reg.irq;
  assign keypad_wake = st_reg.wake;

  // ==========================================================
  // checks
  // ==========================================================
  // matched line flags
  AST_FLAG_SET: assert property (
    @(posedge mclk) disable iff (!nrst)
    (hit != '0) |=> ((flags_set & $past(hit)) == $past(hit)))
    else $error("matched line did not set its flag");

  AST_NO_SPUR: assert property (
    @(posedge mclk) disable iff (!nrst)
    (flags_set & ~$past(flags_set) & ~$past(hit)) == '0)
    else $error("flag set on an unmatched line");

  AST_READ_CLR: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sfr_rd && sfr_addr == KLI_OFS_LINE_FLAGS)
    |=> flags_set == $past(hit))
    else $error("flag read did not clear flags");

  AST_WR_NOFX: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sfr_wr && !sfr_rd && hit == '0) |=> $stable(flags_set))
    else $error("write changed flags");

  AST_FLAG_HOLD: assert property (
    @(posedge mclk) disable iff (!nrst)
    !(sfr_rd && sfr_addr == KLI_OFS_LINE_FLAGS)
    |=> ((flags_set & $past(flags_set)) == $past(flags_set)))
    else $error("flag dropped without a read");

  AST_RD_FLAGS: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sfr_rd && sfr_addr == KLI_OFS_LINE_FLAGS)
    |=> sfr_rdata == $past(flags_set))
    else $error("flag read returned wrong value");

  AST_RD_IDLE: assert property (
    @(posedge mclk) disable iff (!nrst)
    !sfr_rd |=> sfr_rdata == KLI_READ_ZERO)
    else $error("read data not zero without a read");

  AST_RST_ZERO: assert property (
    @(posedge mclk)
    $rose(nrst) |-> (flags_set == KLI_RST_BYTE
      && st_reg.line_enable == KLI_RST_BYTE
      && st_reg.level_select == KLI_RST_BYTE))
    else $error("register not zero after reset");

  AST_MASKED: assert property (
    @(posedge mclk) disable iff (!nrst)
    ((flags_set & st_reg.line_enable) == '0) |=> !keypad_irq)
    else $error("masked flag raised request");

  AST_WAKE_MASK: assert property (
    @(posedge mclk) disable iff (!nrst)
    ((flags_set & st_reg.line_enable) == '0) |=> !keypad_wake)
    else $error("masked flag raised wake");

  AST_RAISE: assert property (
    @(posedge mclk) disable iff (!nrst)
    (keypad_global_irq_enable && (flags_set & st_reg.line_enable) != '0)
    |=> keypad_irq)
    else $error("enabled flag gave no request");

  AST_EN_WRITE: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sfr_wr && sfr_addr == KLI_OFS_LINE_ENABLE)
    |=> st_reg.line_enable == $past(sfr_wdata))
    else $error("enable write lost");

  AST_LOW_SEL: assert property (
    @(posedge mclk) disable iff (!nrst)
    ((~st_reg.level_select & ~st_reg.sync2) != '0) |=>
    ((flags_set & $past(~st_reg.level_select & ~st_reg.sync2))
      == $past(~st_reg.level_select & ~st_reg.sync2)))
    else $error("low level not detected");

  AST_LS_WRITE: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sfr_wr && sfr_addr == KLI_OFS_LEVEL_SELECT)
    |=> st_reg.level_select == $past(sfr_wdata))
    else $error("level select write lost");

  AST_HIGH_SEL: assert property (
    @(posedge mclk) disable iff (!nrst)
    ((st_reg.level_select & st_reg.sync2) != '0) |=>
    ((flags_set & $past(st_reg.level_select & st_reg.sync2))
      == $past(st_reg.level_select & st_reg.sync2)))
    else $error("high level not detected");

  AST_GLOBAL: assert property (
    @(posedge mclk) disable iff (!nrst)
    !keypad_global_irq_enable |=> !keypad_irq)
    else $error("request passed global gate");

  AST_WAKE: assert property (
    @(posedge mclk) disable iff (!nrst)
    ((flags_set & st_reg.line_enable) != '0) |=> keypad_wake)
    else $error("no wake on enabled flag");

  AST_REARM: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sfr_rd && sfr_addr == KLI_OFS_LINE_FLAGS && hit != '0)
    |=> flags_set != '0)
    else $error("held key lost its flag on read");

  AST_SYNC: assert property (
    @(posedge mclk) disable iff (!nrst)
    ##2 st_reg.sync2 == $past(port_one, 2))
    else $error("sync depth wrong");
endmodule

// file: kli_matrix.sv
// keyboard matrix model: a pressed key pulls its line low
module kli_matrix (
  // key presses from the bench
  input wire logic [7:0] press,
  // lines toward the port pins
  output logic [7:0] port_one
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-ups hold released lines high
  assign port_one = ~press;
endmodule

// file: keypad_level_interrupt_bench.sv
// self-checking bench for the keypad level unit
`define CHK(g, e) chk(g, e)
module keypad_level_interrupt_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import kli_pkg::*;
  logic mclk = 0, nrst = 0, sfr_wr = 0, sfr_rd = 0, gen = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, press = 0, v;
  logic [7:0] sfr_rdata, port_one;
  logic keypad_irq, keypad_wake;
  int n_errors = 0, compares = 0, cyc = 0;
  kli_matrix mx (.press(press), .port_one(port_one));
  kli_keypad uut (.mclk(mclk), .nrst(nrst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .keypad_global_irq_enable(gen),
    .keypad_irq(keypad_irq), .keypad_wake(keypad_wake),
    .port_one(port_one));
  initial forever #2 mclk = ~mclk;
  // =====================
  // tasks
  task chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_addr = a; sfr_wdata = d; sfr_wr = 1;
    @(negedge mclk);
    sfr_wr = 0;
  endtask
  // read data lands one cycle after the read edge
  task rd(input logic [7:0] a);
    @(negedge mclk);
    sfr_addr = a; sfr_rd = 1;
    @(negedge mclk);
    sfr_rd = 0; v = sfr_rdata;
  endtask
  task idle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task give_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard well above the roughly 70 cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      give_verdict;
    end
  end
  // =====================
  // tests
  initial begin
    idle(2);
    nrst = 1;
    idle(4);
    rd(KLI_OFS_LEVEL_SELECT); `CHK(v, KLI_RST_BYTE);
    rd(KLI_OFS_LINE_ENABLE); `CHK(v, KLI_RST_BYTE);
    rd(KLI_OFS_LINE_FLAGS); `CHK(v, KLI_RST_BYTE);
    $display("test reset done");
    wr(KLI_OFS_LINE_ENABLE, 8'hFF); gen = 1; press = 8'h04; idle(6);
    `CHK(keypad_irq, 1'b1);
    rd(KLI_OFS_LINE_FLAGS); `CHK(v, 8'h04);
    rd(KLI_OFS_LINE_FLAGS); `CHK(v, 8'h04);
    press = 0; idle(4);
    rd(KLI_OFS_LINE_FLAGS); `CHK(v, 8'h04);
    rd(KLI_OFS_LINE_FLAGS); `CHK(v, 8'h00);
    `CHK(keypad_irq, 1'b0);
    wr(KLI_OFS_LINE_FLAGS, 8'hFF); rd(KLI_OFS_LINE_FLAGS);
    `CHK(v, 8'h00);
    rd(8'h10); `CHK(v, KLI_READ_ZERO);
    $display("test flags done");
    wr(KLI_OFS_LINE_ENABLE, 8'hFB); press = 8'h04; idle(6);
    `CHK(keypad_irq, 1'b0);
    `CHK(keypad_wake, 1'b0);
    wr(KLI_OFS_LINE_ENABLE, 8'hFF); gen = 0; idle(4);
    `CHK(keypad_irq, 1'b0);
    `CHK(keypad_wake, 1'b1);
    press = 0; idle(4); rd(KLI_OFS_LINE_FLAGS);
    wr(KLI_OFS_LEVEL_SELECT, 8'h80); idle(6);
    rd(KLI_OFS_LINE_FLAGS); `CHK(v, 8'h80);
    rd(KLI_OFS_LEVEL_SELECT); `CHK(v, 8'h80);
    $display("test gating and level done");
    give_verdict;
  end
endmodule
